// ---- src/usbh_ctrl.sv ----
// host-side controller for the usb endpoint-0 and interrupt enables
// Function
// - write in-endpoint enables to bits 5:0
// - write out-endpoint enables to bits 5:0
// - bus event enables written with bits 7:5 zero
// - clear setup-changed by writing one only
// - data-stage stall set by software write one
// - software sets data-stage stall after last transaction
// - out0 busy read-only, armed by byte-count write
// - out0 buffer untouched while out0 busy (only buffer commands check it; raw writes reach the buffer unchecked)
// - in0 busy read-only, armed by byte-count write
// - in0 buffer untouched while in0 busy (only buffer commands check it; raw writes reach the buffer unchecked)
// - status-nak cleared by software writing one
// - endpoint stall set by writing one
// - request flags cleared by writing one
`timescale 1ns/1ns
module usbh_ctrl (
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o,
   output logic [15:0]      dev_addr_o,
   output logic [7:0]       dev_wdata_o,
   output logic             dev_wr_o,
   output logic             dev_rd_o,
   input  wire logic [7:0]  dev_rdata_i,
   input  wire logic        dev_irq_i
);
   typedef enum logic [1:0] {
      C_IDLE = 2'h0,
      C_CHK  = 2'h1,
      C_REL  = 2'h2,
      C_ACC  = 2'h3
   } usbh_ctl_st_t;

   usbh_acc_if acc ();

   usbh_devbus #(
      .STROBE_CYC (usbh_pkg::DEV_STROBE_CYC)
   ) u_devbus (
      .core_clk_i  (core_clk_i),
      .nrst_i      (nrst_i),
      .acc         (acc.eng),
      .dev_addr_o  (dev_addr_o),
      .dev_wdata_o (dev_wdata_o),
      .dev_wr_o    (dev_wr_o),
      .dev_rd_o    (dev_rd_o),
      .dev_rdata_i (dev_rdata_i)
   );

   // true when a lies inside the inclusive window lo..hi
   function automatic logic in_rng(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // turn one command word into one device access
   function automatic usbh_pkg::usbh_acc_t cmd_map(input logic [31:0] c);
      usbh_pkg::usbh_acc_t m;
      logic [7:0]          d;
      d       = c[usbh_pkg::CMD_DATA_LSB +: 8];
      m.wr    = 1'b1;
      m.addr  = c[15:0];
      m.wdata = d;
      case (usbh_pkg::usbh_op_t'(c[usbh_pkg::CMD_OP_LSB +: 3]))
         usbh_pkg::OP_RAW_WR: m.wr = 1'b1;       // flag clears use ones
         usbh_pkg::OP_RAW_RD: m.wr = 1'b0;
         usbh_pkg::OP_IEN_IN: begin
            m.addr  = usbh_pkg::DEV_IN_IEN;
            m.wdata = d & usbh_pkg::EP_IEN_MASK;
         end
         usbh_pkg::OP_IEN_OUT: begin
            m.addr  = usbh_pkg::DEV_OUT_IEN;
            m.wdata = d & usbh_pkg::EP_IEN_MASK;
         end
         usbh_pkg::OP_IEN_BUS: begin
            m.addr  = usbh_pkg::DEV_BUS_IEN;
            m.wdata = d & usbh_pkg::BUS_IEN_MASK;
         end
         // only write-one action bits pass; busy bits are read-only
         usbh_pkg::OP_EP0_CTL: begin
            m.addr  = usbh_pkg::DEV_EP0_CS;
            m.wdata = d & usbh_pkg::EP0_WR_MASK;
         end
         // any write to the byte count arms the buffer
         usbh_pkg::OP_ARM: m.addr = c[0] ? usbh_pkg::DEV_OUT0_BC
                                         : usbh_pkg::DEV_IN0_BC;
         usbh_pkg::OP_BUF: m.wr = c[usbh_pkg::CMD_DIR_BIT];
         default: m.wr = 1'b0;
      endcase
      return m;
   endfunction

   // ahb address phase capture
   logic       wr_pend_q, wr_pend_d;
   logic [7:0] wa_q, wa_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic        hrdy_q, hresp_q;
   logic        take;

   // controller state
   usbh_ctl_st_t        st_q, st_d;
   logic                req_q, req_d;
   logic                wr_q, wr_d;
   logic [15:0]         addr_q, addr_d;
   logic [7:0]          wdata_q, wdata_d;
   usbh_pkg::usbh_acc_t buf_q, buf_d;
   logic                refused_q, refused_d;
   logic [7:0]          rdata_q, rdata_d;
   logic [7:0]          ep0_q, ep0_d;
   logic                irq_s1_q, irq_s2_q;

   logic                cmd_go;
   usbh_pkg::usbh_acc_t cmd;
   logic                is_buf, buf_in, buf_out, busy_hit;
   logic [2:0]          cmd_op;

   assign take   = hsel_i && hready_i && htrans_i[1] &&
                   (hsize_i == usbh_pkg::HSIZE_WORD);
   assign cmd_go = wr_pend_q && (wa_q == usbh_pkg::REG_CMD);
   assign cmd    = cmd_map(hwdata_i);
   assign cmd_op = hwdata_i[usbh_pkg::CMD_OP_LSB +: 3];
   assign is_buf = cmd_op == usbh_pkg::OP_BUF;
   assign buf_in = in_rng(hwdata_i[15:0], usbh_pkg::DEV_IN0_LO,
                          usbh_pkg::DEV_IN0_HI);
   assign buf_out = in_rng(hwdata_i[15:0], usbh_pkg::DEV_OUT0_LO,
                           usbh_pkg::DEV_OUT0_HI);
   // owner bit matching the buffer the pending access targets
   assign busy_hit = in_rng(buf_q.addr, usbh_pkg::DEV_IN0_LO,
                            usbh_pkg::DEV_IN0_HI)
                     ? acc.rdata[usbh_pkg::CS_INBSY]
                     : acc.rdata[usbh_pkg::CS_OUTBSY];

   // bus slave: read data registered in the address phase, zero wait
   always_comb begin
      wr_pend_d = take && hwrite_i;
      wa_d      = take ? haddr_i[7:0] : wa_q;
      hrdata_d  = hrdata_q;
      if (take && !hwrite_i) begin
         case (haddr_i[7:0])
            usbh_pkg::REG_STAT: begin
               hrdata_d = {24'h000000, rdata_q};
               hrdata_d[usbh_pkg::ST_BUSY]    = st_q != C_IDLE;
               hrdata_d[usbh_pkg::ST_REFUSED] = refused_q;
               hrdata_d[usbh_pkg::ST_IRQ]     = irq_s2_q;
            end
            usbh_pkg::REG_EP0: hrdata_d = {24'h000000, ep0_q};
            default: hrdata_d = 32'h00000000;
         endcase
      end
   end

   // sequencer: buffer accesses first read the owner bits
   always_comb begin
      st_d      = st_q;
      req_d     = req_q;
      wr_d      = wr_q;
      addr_d    = addr_q;
      wdata_d   = wdata_q;
      buf_d     = buf_q;
      refused_d = refused_q;
      rdata_d   = rdata_q;
      ep0_d     = ep0_q;
      case (st_q)
         C_IDLE: if (cmd_go) begin
            refused_d = 1'b0;
            if (is_buf && !(buf_in || buf_out)) begin
               refused_d = 1'b1;
            end else if (is_buf) begin
               buf_d  = cmd;
               req_d  = 1'b1;
               wr_d   = 1'b0;
               addr_d = usbh_pkg::DEV_EP0_CS;
               st_d   = C_CHK;
            end else begin
               req_d   = 1'b1;
               wr_d    = cmd.wr;
               addr_d  = cmd.addr;
               wdata_d = cmd.wdata;
               st_d    = C_ACC;
            end
         end
         C_CHK: if (acc.ack) begin
            req_d = 1'b0;
            ep0_d = acc.rdata;
            if (busy_hit) begin
               refused_d = 1'b1;
               st_d      = C_IDLE;
            end else begin
               st_d = C_REL;
            end
         end
         // one idle cycle lets the engine see the request drop
         C_REL: begin
            req_d   = 1'b1;
            wr_d    = buf_q.wr;
            addr_d  = buf_q.addr;
            wdata_d = buf_q.wdata;
            st_d    = C_ACC;
         end
         C_ACC: if (acc.ack) begin
            req_d = 1'b0;
            if (!wr_q) rdata_d = acc.rdata;
            // status image shows chgset, stalls and busy bits
            if (!wr_q && addr_q == usbh_pkg::DEV_EP0_CS) ep0_d = acc.rdata;
            st_d = C_IDLE;
         end
         default: st_d = C_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         wr_pend_q <= 1'b0;
         wa_q      <= usbh_pkg::RST_BYTE;
         hrdata_q  <= 32'h00000000;
         hrdy_q    <= 1'b1;
         hresp_q   <= 1'b0;
         st_q      <= C_IDLE;
         req_q     <= 1'b0;
         wr_q      <= 1'b0;
         addr_q    <= 16'h0000;
         wdata_q   <= usbh_pkg::RST_BYTE;
         buf_q     <= '0;
         refused_q <= 1'b0;
         rdata_q   <= usbh_pkg::RST_BYTE;
         ep0_q     <= usbh_pkg::RST_BYTE;
      end else begin
         wr_pend_q <= wr_pend_d;
         wa_q      <= wa_d;
         hrdata_q  <= hrdata_d;
         hrdy_q    <= 1'b1;
         hresp_q   <= 1'b0;
         st_q      <= st_d;
         req_q     <= req_d;
         wr_q      <= wr_d;
         addr_q    <= addr_d;
         wdata_q   <= wdata_d;
         buf_q     <= buf_d;
         refused_q <= refused_d;
         rdata_q   <= rdata_d;
         ep0_q     <= ep0_d;
      end
   end

   // device interrupt pin is asynchronous; only the second stage is read
   always_ff @(posedge core_clk_i) begin
      irq_s1_q <= dev_irq_i;
      irq_s2_q <= irq_s1_q;
   end

   assign hreadyout_o = hrdy_q;
   assign hresp_o     = hresp_q;
   assign hrdata_o    = hrdata_q;
   assign acc.req     = req_q;
   assign acc.wr      = wr_q;
   assign acc.addr    = addr_q;
   assign acc.wdata   = wdata_q;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_chk_busy;
      st_q == C_CHK && acc.ack && busy_hit;
   endsequence
   sequence s_chk_free;
      st_q == C_CHK && acc.ack && !busy_hit;
   endsequence

   a_bus_ien_zero: assert property (
      req_q && wr_q && addr_q == usbh_pkg::DEV_BUS_IEN
      |-> wdata_q[7:5] == 3'h0)
      else $error("bus enable write with upper bits set");
   a_in_ien_bits: assert property (
      cmd_go && st_q == C_IDLE && cmd_op == usbh_pkg::OP_IEN_IN
      |=> addr_q == usbh_pkg::DEV_IN_IEN && wdata_q ==
          ($past(hwdata_i[23:16]) & usbh_pkg::EP_IEN_MASK))
      else $error("in enable write wrong");
   a_out_ien_bits: assert property (
      cmd_go && st_q == C_IDLE && cmd_op == usbh_pkg::OP_IEN_OUT
      |=> addr_q == usbh_pkg::DEV_OUT_IEN && wdata_q[7:6] == 2'h0)
      else $error("out enable write wrong");
   a_ep0_ro_bits: assert property (
      req_q && wr_q && addr_q == usbh_pkg::DEV_EP0_CS
      |-> (wdata_q & ~usbh_pkg::EP0_WR_MASK) == 8'h00)
      else $error("control write touches read-only bits");
   a_busy_refuse: assert property (
      s_chk_busy |=> st_q == C_IDLE && refused_q && !req_q)
      else $error("busy buffer access not refused");
   a_free_access: assert property (
      s_chk_free ##1 st_q == C_REL |=> req_q && addr_q == buf_q.addr)
      else $error("free buffer access not issued");
   a_arm_out0: assert property (
      cmd_go && st_q == C_IDLE && cmd_op == usbh_pkg::OP_ARM && hwdata_i[0]
      |=> req_q && wr_q && addr_q == usbh_pkg::DEV_OUT0_BC)
      else $error("out0 arm does not write byte count");
   a_arm_in0: assert property (
      cmd_go && st_q == C_IDLE && cmd_op == usbh_pkg::OP_ARM && !hwdata_i[0]
      |=> req_q && wr_q && addr_q == usbh_pkg::DEV_IN0_BC)
      else $error("in0 arm does not write byte count");
   a_req_done: assert property (
      $rose(req_q) |-> ##[1:40] acc.ack ##1 !req_q)
      else $error("device access did not finish");
endmodule

// ---- src/usbh_pkg.sv ----
// constants and types shared by the endpoint-0 host-side controller
package usbh_pkg;
   // device register and buffer addresses
   localparam logic [15:0] DEV_IN_IEN   = 16'hc7ac;
   localparam logic [15:0] DEV_OUT_IEN  = 16'hc7ad;
   localparam logic [15:0] DEV_BUS_IEN  = 16'hc7ae;
   localparam logic [15:0] DEV_EP0_CS   = 16'hc7b4;
   localparam logic [15:0] DEV_IN0_BC   = 16'hc7b5;
   localparam logic [15:0] DEV_OUT0_BC  = 16'hc7c5;
   localparam logic [15:0] DEV_IN0_LO   = 16'hc700;
   localparam logic [15:0] DEV_IN0_HI   = 16'hc71f;
   localparam logic [15:0] DEV_OUT0_LO  = 16'hc6c0;
   localparam logic [15:0] DEV_OUT0_HI  = 16'hc6ff;
   // device field masks and bit positions
   localparam logic [7:0]  EP_IEN_MASK  = 8'h3f;
   localparam logic [7:0]  BUS_IEN_MASK = 8'h1f;
   localparam logic [7:0]  EP0_WR_MASK  = 8'h33;
   localparam int          CS_OUTBSY    = 3;
   localparam int          CS_INBSY     = 2;
   // own register offsets on the ahb side
   localparam logic [7:0]  REG_CMD      = 8'h00;
   localparam logic [7:0]  REG_STAT     = 8'h04;
   localparam logic [7:0]  REG_EP0      = 8'h08;
   // command word fields
   localparam int          CMD_DATA_LSB = 16;
   localparam int          CMD_OP_LSB   = 24;
   localparam int          CMD_DIR_BIT  = 27;
   // status word fields
   localparam int          ST_BUSY      = 8;
   localparam int          ST_REFUSED   = 9;
   localparam int          ST_IRQ       = 10;
   // reset value and word transfer size
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [2:0]  HSIZE_WORD   = 3'h2;
   // device strobe timing
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          DEV_STROBE_NS = 40;
   localparam int          DEV_STROBE_CYC =
      (DEV_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SYNC_STAGES  = 2;

   typedef enum logic [2:0] {
      OP_RAW_WR  = 3'h0,
      OP_RAW_RD  = 3'h1,
      OP_IEN_IN  = 3'h2,
      OP_IEN_OUT = 3'h3,
      OP_IEN_BUS = 3'h4,
      OP_EP0_CTL = 3'h5,
      OP_ARM     = 3'h6,
      OP_BUF     = 3'h7
   } usbh_op_t;

   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } usbh_acc_t;
endpackage

// ---- src/usbh_acc_if.sv ----
// access channel between command sequencer and device bus engine
`timescale 1ns/1ns
interface usbh_acc_if;
   logic        req;
   logic        wr;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        ack;
   logic [7:0]  rdata;
   modport ctl (output req, wr, addr, wdata, input ack, rdata);
   modport eng (input req, wr, addr, wdata, output ack, rdata);
endinterface

// ---- src/usbh_devbus.sv ----
// device register bus engine: one byte access per request
`timescale 1ns/1ns
module usbh_devbus #(
   parameter int STROBE_CYC = usbh_pkg::DEV_STROBE_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   usbh_acc_if.eng          acc,
   output logic [15:0]      dev_addr_o,
   output logic [7:0]       dev_wdata_o,
   output logic             dev_wr_o,
   output logic             dev_rd_o,
   input  wire logic [7:0]  dev_rdata_i
);
   if (STROBE_CYC < 1 || STROBE_CYC + usbh_pkg::SYNC_STAGES > 256) begin
      $error("usbh_devbus: STROBE_CYC out of range");
   end

   typedef enum logic [1:0] {
      E_IDLE = 2'h0,
      E_STRB = 2'h1,
      E_DONE = 2'h2
   } usbh_eng_st_t;

   usbh_eng_st_t st_q, st_d;
   logic [7:0]   cnt_q, cnt_d;
   logic [15:0]  addr_q, addr_d;
   logic [7:0]   wdata_q, wdata_d;
   logic         wr_q, wr_d, rd_q, rd_d, ack_q, ack_d;
   logic [7:0]   rdata_q, rdata_d;
   logic [7:0]   sync1_q, sync2_q;

   // reads hold the strobe long enough for the pin data to clear the sync
   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      addr_d  = addr_q;
      wdata_d = wdata_q;
      wr_d    = wr_q;
      rd_d    = rd_q;
      rdata_d = rdata_q;
      ack_d   = 1'b0;
      case (st_q)
         E_IDLE: if (acc.req) begin
            addr_d  = acc.addr;
            wdata_d = acc.wdata;
            wr_d    = acc.wr;
            rd_d    = !acc.wr;
            cnt_d   = acc.wr ? 8'(STROBE_CYC - 1)
                             : 8'(STROBE_CYC + usbh_pkg::SYNC_STAGES - 1);
            st_d    = E_STRB;
         end
         E_STRB: if (cnt_q == 8'h00) begin
            wr_d  = 1'b0;
            rd_d  = 1'b0;
            if (rd_q) rdata_d = sync2_q;
            ack_d = 1'b1;
            st_d  = E_DONE;
         end else begin
            cnt_d = cnt_q - 8'h01;
         end
         // wait for the request to drop so one request is one access
         E_DONE: if (!acc.req) st_d = E_IDLE;
         default: st_d = E_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         st_q    <= E_IDLE;
         cnt_q   <= 8'h00;
         addr_q  <= 16'h0000;
         wdata_q <= 8'h00;
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
         rdata_q <= 8'h00;
         ack_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         addr_q  <= addr_d;
         wdata_q <= wdata_d;
         wr_q    <= wr_d;
         rd_q    <= rd_d;
         rdata_q <= rdata_d;
         ack_q   <= ack_d;
      end
   end

   // pin data comes from another domain: two stages before use
   always_ff @(posedge core_clk_i) begin
      sync1_q <= dev_rdata_i;
      sync2_q <= sync1_q;
   end

   assign dev_addr_o  = addr_q;
   assign dev_wdata_o = wdata_q;
   assign dev_wr_o    = wr_q;
   assign dev_rd_o    = rd_q;
   assign acc.ack     = ack_q;
   assign acc.rdata   = rdata_q;

   a_strobe_excl: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      !(wr_q && rd_q))
      else $error("write and read strobes overlap");
   a_ack_single: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      ack_q |=> !ack_q && !wr_q && !rd_q)
      else $error("ack longer than one cycle");
endmodule

// ---- sim/usbh_dev_model.sv ----
// behavioural model of the usb device registers behind the controller
`timescale 1ns/1ns
module usbh_dev_model (
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   input  wire logic [15:0] dev_addr_i,
   input  wire logic [7:0]  dev_wdata_i,
   input  wire logic        dev_wr_i,
   input  wire logic        dev_rd_i,
   output logic [7:0]       dev_rdata_o,
   output logic             dev_irq_o,
   input  wire logic        setup_tok_i,
   input  wire logic        setup_dat_i,
   input  wire logic [1:0]  host_i,
   output logic [1:0]       hs_o
);
   logic [7:0] in_ien_q, out_ien_q, bus_ien_q, ep0_q;
   logic [7:0] in_flag_q, out_flag_q, bus_flag_q, last_q, rd_val;
   logic [7:0] mem_q [0:255];
   logic       wr_q;
   logic       in_buf;
   // both endpoint-0 buffers fold into one array without overlap
   assign in_buf = (dev_addr_i >= 16'hc700 && dev_addr_i <= 16'hc71f) ||
                   (dev_addr_i >= 16'hc6c0 && dev_addr_i <= 16'hc6ff);
   // register file, written once at the start of each write strobe
   always @(posedge core_clk_i) begin
      wr_q <= dev_wr_i;
      if (!nrst_i) begin
         {in_ien_q, out_ien_q, bus_ien_q, ep0_q} <= 32'h0;
         {in_flag_q, out_flag_q, bus_flag_q} <= 24'h0;
         for (int i = 0; i < 256; i++) mem_q[i] <= 8'h00;
      end else begin
         if (dev_wr_i && !wr_q) begin
            case (dev_addr_i)
               16'hc7ac: in_ien_q <= dev_wdata_i;
               16'hc7ad: out_ien_q <= dev_wdata_i;
               16'hc7ae: bus_ien_q <= dev_wdata_i;
               16'hc7a9: in_flag_q <= in_flag_q & ~dev_wdata_i;
               16'hc7aa: out_flag_q <= out_flag_q & ~dev_wdata_i;
               16'hc7ab: bus_flag_q <= bus_flag_q & ~dev_wdata_i;
               // busy bits are kept, bits 7:6 stay zero, the rest is one-to-set or clear
               16'hc7b4: ep0_q <= {2'b00, ep0_q[5] & ~dev_wdata_i[5],
                  ep0_q[4] | dev_wdata_i[4], ep0_q[3:2],
                  ep0_q[1] & ~dev_wdata_i[1],
                  ep0_q[0] | dev_wdata_i[0]};
               16'hc7b5: ep0_q[2] <= 1'b1;
               16'hc7c5: ep0_q[3] <= 1'b1;
               default: if (in_buf) mem_q[dev_addr_i[7:0]] <= dev_wdata_i;
            endcase
         end
         // setup token releases both buffers and stalls, naks status
         if (setup_tok_i) begin
            ep0_q[4:0] <= 5'b00010;
            bus_flag_q[2] <= 1'b1;
         end
         if (setup_dat_i) begin
            ep0_q[5] <= 1'b1;
            bus_flag_q[0] <= 1'b1;
         end
         // data-stage traffic, 1 in, 2 out; dstall turns it into a stall
         if (host_i == 2'h1 || host_i == 2'h2) begin
            if (ep0_q[4]) ep0_q[0] <= 1'b1;
            else if (!ep0_q[0]) begin
               if (host_i[0]) in_flag_q[0] <= 1'b1;
               else out_flag_q[0] <= 1'b1;
            end
         end
      end
      if (dev_rd_i) last_q <= rd_val;
   end
   // read mux; a released bus shows the inverse, never a stale byte
   always_comb begin
      case (dev_addr_i)
         16'hc7ac: rd_val = in_ien_q;
         16'hc7ad: rd_val = out_ien_q;
         16'hc7ae: rd_val = bus_ien_q;
         16'hc7a9: rd_val = in_flag_q;
         16'hc7aa: rd_val = out_flag_q;
         16'hc7ab: rd_val = bus_flag_q;
         16'hc7b4: rd_val = ep0_q;
         default: rd_val = in_buf ? mem_q[dev_addr_i[7:0]] : 8'h00;
      endcase
      dev_rdata_o = dev_rd_i ? rd_val : ~last_q;
   end
   // handshake 0 ack, 1 nak, 2 stall; host_i of 3 is the status stage
   always_comb begin
      hs_o = {ep0_q[4] | ep0_q[0], 1'b0};
      if (host_i == 2'h3)
         hs_o = ep0_q[0] ? 2'h2 : {1'b0, ep0_q[1]};
   end
   // only enabled flags reach the interrupt line
   assign dev_irq_o = |(in_flag_q & in_ien_q & 8'h3f) |
                      |(out_flag_q & out_ien_q & 8'h3f) |
                      |(bus_flag_q & bus_ien_q & 8'h1f);
endmodule

// ---- sim/usbh_ctrl_bench.sv ----
// self-checking bench for the endpoint-0 host-side controller
`timescale 1ns/1ns
module usbh_ctrl_bench;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        tok = 1'b0;
   logic        dat = 1'b0;
   logic [1:0]  host = 2'h0;
   logic [1:0]  hs;
   logic        hready, hresp, dev_wr, dev_rd, dev_irq;
   logic [31:0] hrdata, stat, rdw;
   logic [15:0] dev_addr;
   logic [7:0]  dev_wdata, dev_rdata, ep0, d;
   logic [15:0] ien_adr [3] = '{16'hc7ac, 16'hc7ad, 16'hc7ae};
   logic [7:0]  ien_msk [3] = '{8'h3f, 8'h3f, 8'h1f};
   int          miscompares = 0;
   int          total_checks = 0;

   always #5 clk = ~clk;

   usbh_ctrl dut_u (.core_clk_i(clk), .nrst_i(nrst), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
      .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
      .dev_addr_o(dev_addr), .dev_wdata_o(dev_wdata), .dev_wr_o(dev_wr),
      .dev_rd_o(dev_rd), .dev_rdata_i(dev_rdata), .dev_irq_i(dev_irq));
   usbh_dev_model dev_u (.core_clk_i(clk), .nrst_i(nrst),
      .dev_addr_i(dev_addr), .dev_wdata_i(dev_wdata), .dev_wr_i(dev_wr),
      .dev_rd_i(dev_rd), .dev_rdata_o(dev_rdata), .dev_irq_o(dev_irq),
      .setup_tok_i(tok), .setup_dat_i(dat), .host_i(host), .hs_o(hs));

   // ep0 image after a masked control write: one-to-clear, one-to-set
   function automatic logic [7:0] ep0_next(logic [7:0] c, logic [7:0] w);
      return {2'b00, c[5] & ~w[5], c[4] | w[4], c[3:2], c[1] & ~w[1],
              c[0] | w[0]};
   endfunction

   task automatic chk(input logic [31:0] got, exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // one single ahb transfer; entered just after a rising edge
   task automatic ahb(input logic wr, input logic [7:0] off,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, off};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   // issue a command and poll status until the engine is idle
   task automatic cmd(input logic [2:0] op, input logic [15:0] a,
                      input logic [7:0] dv, input logic dir);
      int n;
      n = 0;
      ahb(1'b1, 8'h00, {4'h0, dir, op, dv, a}, stat);
      do begin
         ahb(1'b0, 8'h04, 32'h0, stat);
         n++;
      end while (stat[8] !== 1'b0 && n < 200);
      // a stuck engine ends the run rather than hiding behind the limit
      if (stat[8] !== 1'b0) begin
         chk(stat[8], 1'b0, "engine stuck busy");
         finish_test();
      end
   endtask

   task automatic rd_dev(input logic [15:0] a);
      cmd(3'h1, a, 8'h00, 1'b0);
   endtask

   task automatic irq_chk(input logic e);
      ahb(1'b0, 8'h04, 32'h0, rdw);    // give the synchroniser time
      ahb(1'b0, 8'h04, 32'h0, rdw);
      chk(rdw[10], e, "irq level");
   endtask

   // one host transaction; its handshake is looked at while it stands
   task automatic hev(input logic [1:0] h, input logic [1:0] e);
      host <= h;
      @(posedge clk);
      chk(hs, e, "handshake");
      host <= 2'h0;
      @(posedge clk);
   endtask

   task automatic ev(input logic t, input logic s);
      tok <= t;
      dat <= s;
      @(posedge clk);
      tok <= 1'b0;
      dat <= 1'b0;
      @(posedge clk);
   endtask

   // watchdog sized well above the roughly 900 cycles of the run
   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      finish_test();
   end

   initial begin
      void'($urandom(32'h02dc6f09));
      repeat (12) @(posedge clk);
      chk({hready, hresp, dev_wr, dev_rd}, 32'h8, "reset pins");
      nrst <= 1'b1;
      @(posedge clk);
      ahb(1'b0, 8'h04, 32'h0, rdw);
      chk(rdw, 32'h0, "status after reset");
      // enables: all ones first, then random bytes
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 8'hff : 8'($urandom);
         for (int k = 0; k < 3; k++) begin
            cmd(3'(2 + k), 16'h0, d, 1'b0);
            rd_dev(ien_adr[k]);
            chk(stat[7:0], d & ien_msk[k], "enable");
         end
      end
      // setup token and data: flags recorded, gated by enables
      ev(1'b1, 1'b1);
      cmd(3'h4, 16'h0, 8'h00, 1'b0);
      irq_chk(1'b0);
      cmd(3'h4, 16'h0, 8'h04, 1'b0);
      irq_chk(1'b1);
      cmd(3'h0, 16'hc7ab, 8'h04, 1'b0);
      irq_chk(1'b0);
      cmd(3'h4, 16'h0, 8'h05, 1'b0);
      irq_chk(1'b1);
      cmd(3'h0, 16'hc7ab, 8'h01, 1'b0);
      irq_chk(1'b0);
      ep0 = 8'h22;
      rd_dev(16'hc7b4);
      chk(stat[7:0], ep0, "ep0 after setup");
      // control writes; 8'h10 stalls surplus data-stage tokens
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h10 : 8'($urandom);
         cmd(3'h5, 16'h0, d, 1'b0);
         ep0 = ep0_next(ep0, d);
         rd_dev(16'hc7b4);
         chk(stat[7:0], ep0, "ep0 ctl");
      end
      // arm both buffers, then buffer access must be refused
      cmd(3'h6, 16'h0000, 8'h08, 1'b0);
      cmd(3'h6, 16'h0001, 8'h00, 1'b0);
      ep0 = ep0 | 8'h0c;
      rd_dev(16'hc7b4);
      chk(stat[7:0], ep0, "armed");
      ahb(1'b0, 8'h08, 32'h0, rdw);
      chk(rdw, {24'h0, ep0}, "ep0 image");
      cmd(3'h7, 16'hc700, 8'h5a, 1'b1);
      chk(stat[9], 1'b1, "in0 busy refusal");
      cmd(3'h7, 16'hc6c0, 8'h00, 1'b0);
      chk(stat[9], 1'b1, "out0 busy refusal");
      ev(1'b1, 1'b0);
      ep0 = (ep0 & 8'h20) | 8'h02;
      rd_dev(16'hc7b4);
      chk(stat[7:0], ep0, "token clears");
      d = 8'($urandom);
      cmd(3'h7, 16'hc705, d, 1'b1);
      chk(stat[9], 1'b0, "buffer write");
      cmd(3'h7, 16'hc705, 8'h00, 1'b0);
      chk(stat[9:0], {2'b00, d}, "buffer read");
      cmd(3'h7, 16'hc700, 8'h00, 1'b0);
      chk(stat[9:0], 32'h0, "refused write left no trace");
      cmd(3'h7, 16'hc6bf, 8'h00, 1'b0);
      chk(stat[9], 1'b1, "outside buffer refusal");
      // host traffic against the stall and nak bits
      hev(2'h3, 2'h1);
      hev(2'h1, 2'h0);
      hev(2'h2, 2'h0);
      rd_dev(16'hc7a9);
      chk(stat[7:0], 8'h01, "in0 flag");
      rd_dev(16'hc7aa);
      chk(stat[7:0], 8'h01, "out0 flag");
      cmd(3'h5, 16'h0, 8'h10, 1'b0);
      hev(2'h1, 2'h2);
      rd_dev(16'hc7b4);
      chk(stat[7:0], ep0 | 8'h11, "stall after dstall");
      hev(2'h3, 2'h2);
      ev(1'b1, 1'b0);
      cmd(3'h5, 16'h0, 8'h02, 1'b0);
      hev(2'h3, 2'h0);
      // unmapped and write-only offsets read zero
      ahb(1'b1, 8'h0c, 32'hffffffff, rdw);
      ahb(1'b0, 8'h0c, 32'h0, rdw);
      chk(rdw, 32'h0, "unmapped");
      ahb(1'b0, 8'h00, 32'h0, rdw);
      chk(rdw, 32'h0, "command reads zero");
      finish_test();
   end
endmodule
